/* rtl/edc_defines.svh */
// Purpose: timing counts and field constants for the page-mode dram controller
// Assumes: 200 MHz clock, 5 ns period
// Notes: least times round up, longest times round down
`ifndef EDC_DEFINES_SVH
`define EDC_DEFINES_SVH

`define EDC_CLK_PERIOD_NS 5
`define EDC_ADDR_W 10
`define EDC_DATA_W 16
`define EDC_ROWS 1024
`define EDC_FIFO_DEPTH 4
// minimum row active, row precharge, column precharge, column pulse (ns)
`define EDC_T_RAS_NS 60
`define EDC_T_RP_NS 40
`define EDC_T_CP_NS 10
`define EDC_T_CAS_NS 15
`define EDC_T_RCD_NS 15
`define EDC_T_ACC_NS 60
`define EDC_RAS_CYC ((`EDC_T_RAS_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_RP_CYC ((`EDC_T_RP_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_CP_CYC ((`EDC_T_CP_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_CAS_CYC ((`EDC_T_CAS_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_RCD_CYC ((`EDC_T_RCD_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_ACC_CYC ((`EDC_T_ACC_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
// power-up pause and refresh budget
`define EDC_T_PWR_US 200
`define EDC_PWR_CYC (`EDC_T_PWR_US * 1000 / `EDC_CLK_PERIOD_NS)
`define EDC_INIT_CYCLES 8
`define EDC_T_REFWIN_MS 16
`define EDC_REF_CYC (`EDC_T_REFWIN_MS * 1000000 / `EDC_CLK_PERIOD_NS / `EDC_ROWS)

`endif

/* rtl/edc_pkg.sv */
// Purpose: types for the page-mode dram controller
// Assumes: constants come from edc_defines.svh
// Notes: request word carries write flag, byte lanes, row, column and data
package edc_pkg;
    typedef struct packed {
        logic write;
        logic [1:0] lanes;
        logic [9:0] row;
        logic [9:0] col;
        logic [15:0] data;
    } edc_req_s;

    typedef enum logic [8:0] {
        ST_PWR = 9'h001,
        ST_INIT = 9'h002,
        ST_IDLE = 9'h004,
        ST_ROW = 9'h008,
        ST_COL = 9'h010,
        ST_HOLD = 9'h020,
        ST_CPRE = 9'h040,
        ST_RPRE = 9'h080,
        ST_SELF = 9'h100
    } edc_state_e;
endpackage

/* rtl/edc_fifo.sv */
// Purpose: small request fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: registered read data, honest full and empty
`timescale 1ns/10ps
module edc_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign count = wr_ptr - rd_ptr;
    // output register counts as one of the DEPTH words
    assign in_ready_out = (count + {{AW{1'b0}}, out_valid_out}) < DEPTH[AW:0];
    assign push = in_valid_in && in_ready_out;
    // output register reloads when empty or drained in this cycle
    assign pop = (count != '0) && (!out_valid_out || out_ready_in);

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
            wr_ptr <= '0;
        else if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data_in;
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            rd_ptr <= '0;
            out_valid_out <= 1'b0;
            out_data_out <= '0;
        end
        else if (pop)
        begin
            out_data_out <= mem[rd_ptr[AW-1:0]];
            out_valid_out <= 1'b1;
            rd_ptr <= rd_ptr + 1'b1;
        end
        else if (out_ready_in)
            out_valid_out <= 1'b0;
    end
endmodule

/* rtl/edc_ctrl.sv */
// Purpose: controller driving a 1M x 16 extended-output page dram by its strobes
// Assumes: all inputs synchronous to REF_CLK_IN; one access per row cycle
// Notes: refresh by column-first cycles; optional self refresh on request
`timescale 1ns/10ps
`include "edc_defines.svh"
module edc_ctrl #(
    parameter int PWR_CYC = `EDC_PWR_CYC,
    parameter int REF_CYC = `EDC_REF_CYC
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // request side
    input wire logic REQ_VALID_IN,
    output logic REQ_READY_OUT,
    input wire edc_pkg::edc_req_s REQ_IN,
    // read answer
    output logic RD_VALID_OUT,
    output logic [15:0] RD_DATA_OUT,
    // status and self refresh
    output logic INIT_DONE_OUT,
    input wire logic SELF_REQ_IN,
    output logic SELF_ACTIVE_OUT,
    // dram pins
    output logic RAS_N_OUT,
    output logic LOW_BYTE_COLUMN_STROBE_N_OUT,
    output logic HIGH_BYTE_COLUMN_STROBE_N_OUT,
    output logic WE_N_OUT,
    output logic OE_N_OUT,
    output logic [9:0] ADDR_OUT,
    input wire logic [15:0] DQ_IN,
    output logic [15:0] DQ_OUT,
    output logic DQ_OE_OUT
);
    edc_pkg::edc_state_e state;
    edc_pkg::edc_req_s cur;
    edc_pkg::edc_req_s fifo_data;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_in_ready;
    logic [31:0] timer;
    logic [31:0] ras_timer;
    logic [31:0] ref_timer;
    logic [3:0] init_count;
    logic [10:0] ref_owed;
    logic refresh_cyc;
    logic self_cyc;
    logic take;

    edc_fifo #(
        .WIDTH($bits(edc_pkg::edc_req_s)),
        .DEPTH(`EDC_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(REF_CLK_IN),
        .rst_b_in(RST_B_IN),
        .in_valid_in(REQ_VALID_IN),
        .in_ready_out(fifo_in_ready),
        .in_data_in(REQ_IN),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_data)
    );

    // only accesses consume; refresh has priority over them
    assign take = (state == edc_pkg::ST_IDLE) && INIT_DONE_OUT && (ref_owed == '0) && !SELF_REQ_IN && fifo_valid;
    assign fifo_ready = take;

    // ====================================================================
    // refresh scheduler
    // ====================================================================
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            ref_timer <= '0;
            ref_owed <= '0;
        end
        else
        begin
            // distributed: one row per slot, so no burst after self refresh
            if (ref_timer >= REF_CYC - 1)
                ref_timer <= '0;
            else
                ref_timer <= ref_timer + 1'b1;
            if (state == edc_pkg::ST_SELF)
                ref_owed <= '0;
            else if (ref_timer >= REF_CYC - 1 && !(state == edc_pkg::ST_ROW && timer == '0 && refresh_cyc))
                ref_owed <= ref_owed + 1'b1;
            else if (ref_timer < REF_CYC - 1 && state == edc_pkg::ST_ROW && timer == '0 && refresh_cyc && ref_owed != '0)
                ref_owed <= ref_owed - 1'b1;
        end
    end

    // ====================================================================
    // wake-up cycles counted after the power-up pause
    // ====================================================================
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            init_count <= '0;
            INIT_DONE_OUT <= 1'b0;
        end
        else if (state == edc_pkg::ST_RPRE && timer == '0 && !INIT_DONE_OUT)
        begin
            init_count <= init_count + 1'b1;
            if (init_count == 4'(`EDC_INIT_CYCLES - 1))
                INIT_DONE_OUT <= 1'b1;
        end
    end

    // ====================================================================
    // row active timer, separate from the phase timer
    // ====================================================================
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
            ras_timer <= '0;
        else if (RAS_N_OUT)
            ras_timer <= '0;
        else if (ras_timer < 32'(`EDC_RAS_CYC))
            ras_timer <= ras_timer + 1'b1;
    end

    // ====================================================================
    // cycle sequencer
    // ====================================================================
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            state <= edc_pkg::ST_PWR;
            timer <= '0;
            cur <= '0;
            refresh_cyc <= 1'b0;
            self_cyc <= 1'b0;
            SELF_ACTIVE_OUT <= 1'b0;
            RAS_N_OUT <= 1'b1;
            LOW_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
            HIGH_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
            WE_N_OUT <= 1'b1;
            OE_N_OUT <= 1'b1;
            ADDR_OUT <= '0;
            DQ_OUT <= '0;
            DQ_OE_OUT <= 1'b0;
            RD_VALID_OUT <= 1'b0;
            RD_DATA_OUT <= '0;
            REQ_READY_OUT <= 1'b0;
        end
        else
        begin
            RD_VALID_OUT <= 1'b0;
            REQ_READY_OUT <= fifo_in_ready;
            if (timer != '0)
                timer <= timer - 1'b1;
            case (state)
                edc_pkg::ST_PWR:
                begin
                    // strobes and enables idle high through the pause
                    if (timer == '0 && RAS_N_OUT && !SELF_ACTIVE_OUT && init_count == '0 && !refresh_cyc)
                    begin
                        timer <= 32'(PWR_CYC - 1);
                        refresh_cyc <= 1'b1;
                    end
                    else if (timer == '0)
                        state <= edc_pkg::ST_IDLE;
                end
                edc_pkg::ST_IDLE:
                begin
                    cur <= fifo_data;
                    // wake-up cycles and owed refreshes are column-first cycles
                    if (!INIT_DONE_OUT || ref_owed != '0 || SELF_REQ_IN)
                    begin
                        refresh_cyc <= 1'b1;
                        self_cyc <= INIT_DONE_OUT && ref_owed == '0 && SELF_REQ_IN;
                        LOW_BYTE_COLUMN_STROBE_N_OUT <= 1'b0;
                        HIGH_BYTE_COLUMN_STROBE_N_OUT <= 1'b0;
                        OE_N_OUT <= 1'b1;
                        timer <= 32'(`EDC_CP_CYC - 1);
                        state <= edc_pkg::ST_ROW;
                    end
                    else if (take)
                    begin
                        refresh_cyc <= 1'b0;
                        self_cyc <= 1'b0;
                        ADDR_OUT <= fifo_data.row;
                        timer <= '0;
                        state <= edc_pkg::ST_ROW;
                    end
                end
                edc_pkg::ST_ROW:
                begin
                    if (timer == '0)
                    begin
                        RAS_N_OUT <= 1'b0;
                        if (refresh_cyc)
                        begin
                            timer <= 32'(`EDC_RAS_CYC - 1);
                            state <= self_cyc ? edc_pkg::ST_SELF : edc_pkg::ST_HOLD;
                        end
                        else
                        begin
                            timer <= 32'(`EDC_RCD_CYC - 1);
                            state <= edc_pkg::ST_COL;
                            WE_N_OUT <= !cur.write;
                            // data out ahead of the strobe so it is valid at the later edge
                            DQ_OUT <= cur.data;
                            DQ_OE_OUT <= cur.write;
                        end
                    end
                end
                edc_pkg::ST_COL:
                begin
                    ADDR_OUT <= cur.col;
                    if (timer == '0)
                    begin
                        // strobes fall together, so both lanes share one internal strobe
                        LOW_BYTE_COLUMN_STROBE_N_OUT <= !cur.lanes[0];
                        HIGH_BYTE_COLUMN_STROBE_N_OUT <= !cur.lanes[1];
                        OE_N_OUT <= cur.write;
                        timer <= 32'(`EDC_ACC_CYC - 1);
                        state <= edc_pkg::ST_HOLD;
                    end
                end
                edc_pkg::ST_HOLD:
                begin
                    // end only when access delay and active time both expired
                    if (timer == '0 && ras_timer >= 32'(`EDC_RAS_CYC))
                    begin
                        if (!refresh_cyc && !cur.write)
                        begin
                            RD_DATA_OUT <= DQ_IN;
                            RD_VALID_OUT <= 1'b1;
                        end
                        RAS_N_OUT <= 1'b1;
                        LOW_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
                        HIGH_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
                        WE_N_OUT <= 1'b1;
                        OE_N_OUT <= 1'b1;
                        DQ_OE_OUT <= 1'b0;
                        timer <= 32'(`EDC_CP_CYC - 1);
                        state <= edc_pkg::ST_CPRE;
                    end
                end
                edc_pkg::ST_CPRE:
                begin
                    if (timer == '0)
                    begin
                        timer <= 32'(`EDC_RP_CYC - `EDC_CP_CYC);
                        state <= edc_pkg::ST_RPRE;
                    end
                end
                edc_pkg::ST_RPRE:
                begin
                    if (timer == '0)
                    begin
                        state <= edc_pkg::ST_IDLE;
                        SELF_ACTIVE_OUT <= 1'b0;
                    end
                end
                edc_pkg::ST_SELF:
                begin
                    if (timer == '0 && ras_timer >= 32'(`EDC_RAS_CYC))
                        SELF_ACTIVE_OUT <= 1'b1;
                    if (timer == '0 && ras_timer >= 32'(`EDC_RAS_CYC) && !SELF_REQ_IN)
                    begin
                        RAS_N_OUT <= 1'b1;
                        LOW_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
                        HIGH_BYTE_COLUMN_STROBE_N_OUT <= 1'b1;
                        timer <= 32'(`EDC_RP_CYC - 1);
                        self_cyc <= 1'b0;
                        state <= edc_pkg::ST_RPRE;
                    end
                end
                default:
                    state <= edc_pkg::ST_IDLE;
            endcase
        end
    end
endmodule

/* tb/edc_ctrl_props.sv */
// Purpose: strobe timing checks on edc_ctrl
// Assumes: 5 ns clock, registered strobes
// Notes: internal column strobe is active while either byte strobe is low
`timescale 1ns/10ps
module edc_ctrl_props #(
    parameter int PWR_CYC = 20
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    // dram strobes
    input wire logic RAS_N_OUT,
    input wire logic LOW_BYTE_COLUMN_STROBE_N_OUT,
    input wire logic HIGH_BYTE_COLUMN_STROBE_N_OUT,
    input wire logic WE_N_OUT,
    input wire logic OE_N_OUT,
    input wire logic [9:0] ADDR_OUT,
    input wire logic DQ_OE_OUT,
    // status
    input wire logic RD_VALID_OUT,
    input wire logic INIT_DONE_OUT,
    input wire logic SELF_ACTIVE_OUT
);
    // ==========================================
    // helper counters
    logic cas_n;
    logic [15:0] rl, rh, ch, cyc, nf;
    assign cas_n = LOW_BYTE_COLUMN_STROBE_N_OUT & HIGH_BYTE_COLUMN_STROBE_N_OUT;
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            rl <= 16'h0000;
            rh <= 16'h0000;
            ch <= 16'h0000;
            cyc <= 16'h0000;
            nf <= 16'h0000;
        end
        else
        begin
            rl <= RAS_N_OUT ? 16'h0000 : rl + 16'h0001;
            rh <= RAS_N_OUT ? rh + 16'h0001 : 16'h0000;
            ch <= cas_n ? ch + 16'h0001 : 16'h0000;
            cyc <= (cyc == 16'hFFFF) ? cyc : cyc + 16'h0001;
            nf <= (rh != 16'h0000 && !RAS_N_OUT) ? nf + 16'h0001 : nf;
        end
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_B_IN);
    chk_ras_min_low: assert property ($rose(RAS_N_OUT) |-> rl >= 16'h000C)
        else $error("row strobe released early");
    chk_ras_precharge: assert property ($fell(RAS_N_OUT) |-> rh >= 16'h0008)
        else $error("row precharge too short");
    chk_cas_precharge: assert property ($fell(cas_n) |-> ch >= 16'h0002)
        else $error("column precharge too short");
    chk_read_write_high: assert property (!OE_N_OUT && !cas_n |-> WE_N_OUT && !DQ_OE_OUT)
        else $error("read with write enable low");
    chk_write_data_ready: assert property (!WE_N_OUT && !cas_n |-> DQ_OE_OUT && $past(DQ_OE_OUT))
        else $error("write data late");
    chk_col_addr_hold: assert property (!cas_n && $past(!cas_n) && !RAS_N_OUT && $past(!RAS_N_OUT)
        && !(OE_N_OUT && WE_N_OUT) |-> $stable(ADDR_OUT))
        else $error("column address moved");
    chk_refresh_col_first: assert property ($fell(RAS_N_OUT) && !cas_n |-> $past(!cas_n) && !DQ_OE_OUT)
        else $error("refresh cycle drives data");
    chk_read_answer_time: assert property ($fell(OE_N_OUT) |-> ##[3:24] RD_VALID_OUT)
        else $error("read answer out of window");
    chk_power_on_pause: assert property ($fell(RAS_N_OUT) |-> cyc >= PWR_CYC)
        else $error("row strobe before power pause");
    chk_init_row_cycles: assert property ($rose(INIT_DONE_OUT) |-> nf >= 16'h0008)
        else $error("init done too soon");
    chk_self_row_low: assert property ($rose(SELF_ACTIVE_OUT) |-> !RAS_N_OUT && rl >= 16'h000C)
        else $error("self refresh entry bad");
    cov_init: cover property ($rose(INIT_DONE_OUT));
    cov_read: cover property (RD_VALID_OUT);
    cov_self: cover property ($rose(SELF_ACTIVE_OUT));
endmodule

bind edc_ctrl edc_ctrl_props #(.PWR_CYC(PWR_CYC)) i_edc_ctrl_props (.REF_CLK_IN(REF_CLK_IN),
    .RST_B_IN(RST_B_IN), .RAS_N_OUT(RAS_N_OUT), .LOW_BYTE_COLUMN_STROBE_N_OUT(LOW_BYTE_COLUMN_STROBE_N_OUT),
    .HIGH_BYTE_COLUMN_STROBE_N_OUT(HIGH_BYTE_COLUMN_STROBE_N_OUT), .WE_N_OUT(WE_N_OUT), .OE_N_OUT(OE_N_OUT),
    .ADDR_OUT(ADDR_OUT), .DQ_OE_OUT(DQ_OE_OUT), .RD_VALID_OUT(RD_VALID_OUT), .INIT_DONE_OUT(INIT_DONE_OUT),
    .SELF_ACTIVE_OUT(SELF_ACTIVE_OUT));

/* tb/edc_dram_model.sv */
// Purpose: behavioural page-mode dram, 16 rows by 16 columns kept
// Assumes: strobes sampled on the controller clock
// Notes: undriven data shows the inverse of its last value
`timescale 1ns/10ps
module edc_dram_model (
    // sampling clock
    input wire logic clk_in,
    // strobes and address
    input wire logic ras_n_in,
    input wire logic low_n_in,
    input wire logic high_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic [9:0] addr_in,
    // data
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out
);
    logic [15:0] mem [0:255];
    logic [9:0] row, col;
    logic [15:0] last;
    logic [7:0] rlow, clow;
    logic column_first_refresh, ras_q, cas_q, cas_n, rd_ok;
    logic [1:0] rd_lanes;
    int n_ras, n_cbr;
    assign cas_n = low_n_in & high_n_in;
    initial
    begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
        n_ras = 0;
        n_cbr = 0;
        rd_lanes = 2'b00;
    end
    always @(posedge clk_in)
    begin
        ras_q <= ras_n_in;
        cas_q <= cas_n;
        last <= dq_out;
        rlow <= ras_n_in ? 8'h00 : rlow + 8'h01;
        clow <= (cas_n | oe_n_in) ? 8'h00 : clow + 8'h01;
        // read data outlives the column strobe until its next fall, or until the row strobe or output enable goes high
        if (rd_ok) rd_lanes <= {!high_n_in, !low_n_in};
        else if ((cas_q && !cas_n) || ras_n_in || oe_n_in) rd_lanes <= 2'b00;
        if (ras_n_in) column_first_refresh <= 1'b0;
        if (ras_q && !ras_n_in)
        begin
            row <= addr_in;
            column_first_refresh <= !cas_n;
            n_ras <= n_ras + 1;
            n_cbr <= n_cbr + (cas_n ? 0 : 1);
        end
        if (cas_q && !cas_n && !ras_n_in && !column_first_refresh) col <= addr_in;
        if (!ras_n_in && !cas_n && !cas_q && !we_n_in && !column_first_refresh)
        begin
            // column latched on the edge before and the pins still hold it, so take it from the pins
            if (!low_n_in) mem[{row[3:0], addr_in[3:0]}][7:0] <= dq_in[7:0];
            if (!high_n_in) mem[{row[3:0], addr_in[3:0]}][15:8] <= dq_in[15:8];
        end
    end
    // data valid only once the row and column access delays have run out
    assign rd_ok = !ras_n_in && !cas_n && !oe_n_in && we_n_in && !column_first_refresh && rlow >= 8'h0C && clow >= 8'h03;
    assign dq_out[7:0] = ((rd_ok && !low_n_in) || rd_lanes[0]) ? mem[{row[3:0], col[3:0]}][7:0] : ~last[7:0];
    assign dq_out[15:8] = ((rd_ok && !high_n_in) || rd_lanes[1]) ? mem[{row[3:0], col[3:0]}][15:8] : ~last[15:8];
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for edc_ctrl with a dram model
// Assumes: short power pause and refresh interval parameters
// Notes: inputs change on the falling clock edge
`timescale 1ns/10ps
module tb_top;
    localparam int PWR = 20;
    localparam int REF = 200;
    logic clk, rst_b, req_valid, req_ready, rd_valid, init_done, self_req, self_active;
    logic ras_n, low_n, high_n, we_n, oe_n, dq_oe;
    logic [9:0] addr;
    logic [15:0] rd_data, dq_from_mem, dq_to_mem, dq_bus;
    edc_pkg::edc_req_s req;
    int n_mismatch, n_compared;
    assign dq_bus = dq_oe ? dq_to_mem : dq_from_mem;
    edc_ctrl #(.PWR_CYC(PWR), .REF_CYC(REF)) i_edc_ctrl (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
        .REQ_VALID_IN(req_valid), .REQ_READY_OUT(req_ready), .REQ_IN(req), .RD_VALID_OUT(rd_valid),
        .RD_DATA_OUT(rd_data), .INIT_DONE_OUT(init_done), .SELF_REQ_IN(self_req), .SELF_ACTIVE_OUT(self_active),
        .RAS_N_OUT(ras_n), .LOW_BYTE_COLUMN_STROBE_N_OUT(low_n), .HIGH_BYTE_COLUMN_STROBE_N_OUT(high_n),
        .WE_N_OUT(we_n), .OE_N_OUT(oe_n), .ADDR_OUT(addr), .DQ_IN(dq_bus), .DQ_OUT(dq_to_mem), .DQ_OE_OUT(dq_oe));
    edc_dram_model i_edc_dram_model (.clk_in(clk), .ras_n_in(ras_n), .low_n_in(low_n), .high_n_in(high_n),
        .we_n_in(we_n), .oe_n_in(oe_n), .addr_in(addr), .dq_in(dq_bus), .dq_out(dq_from_mem));
    // ==========================================
    // shared tasks
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task push(input logic w, input logic [1:0] ln, input logic [9:0] r, input logic [9:0] c, input logic [15:0] d);
        for (int k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge clk);
        req = edc_pkg::edc_req_s'{w, ln, r, c, d};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
    endtask
    task rd(input logic [9:0] r, input logic [9:0] c, input logic [15:0] exp);
        push(1'b0, 2'h3, r, c, 16'h0000);
        for (int k = 0; k < 400 && rd_valid !== 1'b1; k++) @(negedge clk);
        check({15'h0000, rd_valid}, 16'h0001);
        check(rd_data, exp);
    endtask
    task wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ==========================================
    // scenarios
    task t_fill_init;
        for (int k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clk);
        push(1'b1, 2'h3, 10'h001, 10'h002, 16'hA5C3);
        push(1'b1, 2'h3, 10'h001, 10'h003, 16'h1234);
        push(1'b1, 2'h1, 10'h001, 10'h002, 16'h5AFF);
        push(1'b1, 2'h2, 10'h002, 10'h002, 16'h0F0F);
        check({15'h0000, req_ready}, 16'h0000);
        check({15'h0000, init_done}, 16'h0000);
        for (int k = 0; k < 2000 && init_done !== 1'b1; k++) @(negedge clk);
        check({15'h0000, i_edc_dram_model.n_ras >= 8}, 16'h0001);
    endtask
    task t_byte_lanes;
        rd(10'h001, 10'h002, 16'hA5FF);
        rd(10'h001, 10'h003, 16'h1234);
        rd(10'h002, 10'h002, 16'h0F00);
    endtask
    task t_refresh;
        int s;
        s = i_edc_dram_model.n_cbr;
        repeat (2000) @(negedge clk);
        check({15'h0000, i_edc_dram_model.n_cbr - s >= 2000 / REF - 1}, 16'h0001);
    endtask
    task t_self;
        self_req = 1'b1;
        for (int k = 0; k < 400 && self_active !== 1'b1; k++) @(negedge clk);
        check({15'h0000, ras_n}, 16'h0000);
        repeat (40) @(negedge clk);
        check({14'h0000, ras_n, self_active}, 16'h0001);
        self_req = 1'b0;
        for (int k = 0; k < 100 && self_active !== 1'b0; k++) @(negedge clk);
        check({15'h0000, self_active}, 16'h0000);
        rd(10'h001, 10'h003, 16'h1234);
    endtask
    // ==========================================
    // clock, reset, sequence, watchdog
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req = '0;
        self_req = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        t_fill_init();
        t_byte_lanes();
        t_refresh();
        t_self();
        wrap_up();
    end
    // run should need about 2500 cycles
    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
